// *** design/stadc_top.sv ***
// Functional notes
// - Result is 12-bit straight binary, zero to full scale 4095.
// - Low start input loads half scale and clears completion flag on the third edge.
// - Completion drain output floats until complete, then drives zero.
// - Code above input: clear trial bit, set next lower bit.
// - Code below input: keep trial and higher bits, set next lower bit.
// - Approximate all 12 bits; deciding bit 0 ends approximation.
// - Completion flag sets two clocks after bit 0 high, holds until restart.
// - Initial conversion takes 13 clock cycles.
// - Track only when complete, start high, freeze high, and follow mode input or control bit low.
// - Tracking steps the count by exactly one per clock.
// - Counter bit toggles when all lower bits match the step direction.
// - Low freeze input holds the result unchanged once complete.
// - Start and freeze inputs pass same-polarity flip-flops before use.
// - Two antiphase clock outputs; the system clock clocks the logic.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
module stadc_top
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_CONV_BEGIN_N,
  input wire logic I_FREEZE_N,
  input wire logic I_FOLLOW_MODE_N,
  input wire logic I_COMPARATOR_RESULT,
  input wire logic [1:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  output logic [11:0] O_RESULT_BITS,
  output logic O_CONVERSION_COMPLETE,
  output logic O_COMPLETE_DRAIN_N_O,
  output logic O_COMPLETE_DRAIN_N_OE,
  output logic O_PHASE_A_CLK,
  output logic O_PHASE_B_CLK,
  output logic O_IRQ
);
  logic conv_begin_sync_n;
  logic freeze_sync_n;
  logic follow_mode_sync_n;
  logic [11:0] result;
  logic [11:0] trial;
  logic complete;
  logic [1:0] status;
  logic [1:0] mask;
  logic follow_sw_n;
  logic [15:0] rdata;
  logic phase_a;
  stadc_pkg::stadc_state_type state;
  logic [11:0] next_result;
  logic [11:0] next_trial;
  logic next_complete;
  logic [1:0] next_status;
  logic [1:0] next_mask;
  logic next_follow_sw_n;
  logic [15:0] next_rdata;
  logic next_phase_a;
  logic next_phase_b;
  stadc_pkg::stadc_state_type next_state;
  logic tracking;
  logic step_event;

  stadc_sync u_sync_begin
  (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_async(I_CONV_BEGIN_N),
    .o_sync(conv_begin_sync_n)
  );

  stadc_sync u_sync_freeze
  (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_async(I_FREEZE_N),
    .o_sync(freeze_sync_n)
  );

  stadc_sync u_sync_follow
  (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_async(I_FOLLOW_MODE_N),
    .o_sync(follow_mode_sync_n)
  );

  // Up/down step built from per-bit toggle terms, as a ripple of all-lower-bits checks
  function automatic logic [11:0] track_step(input logic [11:0] value, input logic code_high);
    logic [11:0] toggles;
    logic run;
    toggles = 12'h000;
    run = 1'b1;
    for (int i = 0; i < stadc_pkg::RESULT_WIDTH; i++)
    begin
      toggles[i] = run;
      run = run & (code_high ? ~value[i] : value[i]);
    end
    return value ^ toggles;
  endfunction

  always_comb
  begin
    tracking = complete && conv_begin_sync_n && freeze_sync_n
               && !(follow_mode_sync_n && follow_sw_n);
    // Comparator read straight at the edge: any extra flop would judge a stale code
    next_state = state;
    next_result = result;
    next_trial = trial;
    next_complete = complete;
    step_event = 1'b0;
    if (!conv_begin_sync_n)
    begin
      next_result = stadc_pkg::HALF_SCALE;
      next_trial = stadc_pkg::HALF_SCALE;
      next_complete = 1'b0;
      next_state = stadc_pkg::STADC_APPROX;
    end
    else
    begin
      case (state)
        stadc_pkg::STADC_APPROX:
        begin
          if (trial == stadc_pkg::ZERO_CODE)
          begin
            // Bit 0 was decided last step, set the step before: flag follows one clock later
            next_complete = 1'b1;
            next_state = stadc_pkg::STADC_DONE;
          end
          else
          begin
            if (I_COMPARATOR_RESULT)
            begin
              next_result = (result & ~trial) | (trial >> 1);
            end
            else
            begin
              next_result = result | (trial >> 1);
            end
            next_trial = trial >> 1;
          end
        end
        stadc_pkg::STADC_DONE:
        begin
          if (tracking && freeze_sync_n)
          begin
            next_result = track_step(result, I_COMPARATOR_RESULT);
            step_event = (next_result != result);
          end
        end
        default:
        begin
          next_state = stadc_pkg::STADC_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    next_status = status;
    next_mask = mask;
    next_follow_sw_n = follow_sw_n;
    next_rdata = 16'h0000;
    if (I_WR)
    begin
      if (I_ADDR == stadc_pkg::REG_STATUS)
      begin
        next_status = status & ~I_WDATA[1:0];
      end
      else if (I_ADDR == stadc_pkg::REG_MASK)
      begin
        next_mask = I_WDATA[1:0];
      end
      else if (I_ADDR == stadc_pkg::REG_CONTROL)
      begin
        next_follow_sw_n = I_WDATA[0];
      end
    end
    // Set wins over a same-cycle clear
    if (next_complete && !complete)
    begin
      next_status[stadc_pkg::INT_CONV_BIT] = 1'b1;
    end
    if (step_event)
    begin
      next_status[stadc_pkg::INT_TRACK_BIT] = 1'b1;
    end
    if (I_RD)
    begin
      if (I_ADDR == stadc_pkg::REG_STATUS)
      begin
        next_rdata = {14'h0000, status};
      end
      else if (I_ADDR == stadc_pkg::REG_MASK)
      begin
        next_rdata = {14'h0000, mask};
      end
      else if (I_ADDR == stadc_pkg::REG_RESULT)
      begin
        next_rdata = {3'h0, complete, result};
      end
      else
      begin
        next_rdata = {15'h0000, follow_sw_n};
      end
    end
    // Two-phase clock: phase B toggles one 20 ns cycle behind phase A, short of the 25 ns PHASE_LAG_NS
    next_phase_a = ~phase_a;
    next_phase_b = phase_a;
  end

  // Phase B is taken from the phase A flop, so no separate state is kept for it

  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      state <= stadc_pkg::STADC_IDLE;
      result <= stadc_pkg::HALF_SCALE;
      trial <= stadc_pkg::HALF_SCALE;
      complete <= 1'b0;
      status <= stadc_pkg::STATUS_RESET;
      mask <= stadc_pkg::MASK_RESET;
      follow_sw_n <= 1'b1;
      O_RDATA <= 16'h0000;
      phase_a <= 1'b0;
      O_RESULT_BITS <= stadc_pkg::HALF_SCALE;
      O_CONVERSION_COMPLETE <= 1'b0;
      O_COMPLETE_DRAIN_N_O <= 1'b0;
      O_COMPLETE_DRAIN_N_OE <= 1'b0;
      O_PHASE_A_CLK <= 1'b0;
      O_PHASE_B_CLK <= 1'b1;
      O_IRQ <= 1'b0;
    end
    else
    begin
      state <= next_state;
      result <= next_result;
      trial <= next_trial;
      complete <= next_complete;
      status <= next_status;
      mask <= next_mask;
      follow_sw_n <= next_follow_sw_n;
      O_RDATA <= next_rdata;
      phase_a <= next_phase_a;
      O_RESULT_BITS <= next_result;
      O_CONVERSION_COMPLETE <= next_complete;
      O_COMPLETE_DRAIN_N_O <= 1'b0;
      O_COMPLETE_DRAIN_N_OE <= next_complete;
      O_PHASE_A_CLK <= next_phase_a;
      O_PHASE_B_CLK <= next_phase_b;
      O_IRQ <= |(next_status & next_mask);
    end
  end
endmodule

// *** design/stadc_pkg.sv ***
package stadc_pkg;
  localparam int RESULT_WIDTH = 12;
  localparam logic [11:0] HALF_SCALE = 12'h800;
  localparam logic [11:0] ZERO_CODE = 12'h000;
  localparam logic [11:0] ONE_CODE = 12'h001;
  localparam int CONV_CYCLES = 13;
  localparam int PHASE_LAG_NS = 25;
  localparam int CLK_PERIOD_NS = 20;
  localparam int PHASE_LAG_CYCLES = (PHASE_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_CONV_BIT = 0;
  localparam int INT_TRACK_BIT = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_MASK = 2'h1;
  localparam logic [1:0] REG_RESULT = 2'h2;
  localparam logic [1:0] REG_CONTROL = 2'h3;
  typedef enum logic [1:0] {STADC_IDLE, STADC_APPROX, STADC_DONE} stadc_state_type;
endpackage

// *** design/stadc_sync.sv ***
`timescale 1ns/1ps
module stadc_sync
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic stage1;
  logic next_stage1;
  logic next_sync;

  always_comb
  begin
    next_stage1 = i_async;
    next_sync = stage1;
  end

  // Reset to the inactive (high) level of the active-low inputs
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      stage1 <= 1'b1;
      o_sync <= 1'b1;
    end
    else
    begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end
endmodule

// *** verif/stadc_analog_model.sv ***
`timescale 1ns/1ps
module stadc_analog_model
(
  input wire logic [11:0] i_code,
  input wire logic [11:0] i_level,
  output logic o_above
);
  // Ideal comparator: no offset, so a settled code equals the level exactly
  assign o_above = i_code > i_level;
endmodule

// *** verif/stadc_checker.sv ***
`timescale 1ns/1ps
module stadc_checker
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_CONV_BEGIN_N,
  input wire logic I_FREEZE_N,
  input wire logic I_FOLLOW_MODE_N,
  input wire logic [11:0] O_RESULT_BITS,
  input wire logic O_CONVERSION_COMPLETE,
  input wire logic O_COMPLETE_DRAIN_N_O,
  input wire logic O_COMPLETE_DRAIN_N_OE,
  input wire logic O_PHASE_A_CLK,
  input wire logic O_PHASE_B_CLK
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);
  sequence s_loaded;
    !O_CONVERSION_COMPLETE && O_RESULT_BITS == stadc_pkg::HALF_SCALE ##1
      O_RESULT_BITS != stadc_pkg::HALF_SCALE;
  endsequence
  sequence s_tracking;
    (O_CONVERSION_COMPLETE && I_CONV_BEGIN_N && I_FREEZE_N && !I_FOLLOW_MODE_N)[*4];
  endsequence
  a_drain_follows: assert property (O_COMPLETE_DRAIN_N_OE == O_CONVERSION_COMPLETE
    && !O_COMPLETE_DRAIN_N_O) else $error("drain pin mismatch");
  a_conv_length: assert property (s_loaded |-> ##12 $rose(O_CONVERSION_COMPLETE))
    else $error("conversion length wrong");
  a_start_clears: assert property ((!I_CONV_BEGIN_N)[*5] |->
    !O_CONVERSION_COMPLETE && O_RESULT_BITS == stadc_pkg::HALF_SCALE) else $error("no restart");
  a_done_holds: assert property ((I_CONV_BEGIN_N[*4] ##0 O_CONVERSION_COMPLETE)
    |=> O_CONVERSION_COMPLETE) else $error("complete flag dropped");
  a_sync_delay: assert property (($fell(I_CONV_BEGIN_N) && O_CONVERSION_COMPLETE)
    |=> O_CONVERSION_COMPLETE) else $error("start acted unsynchronised");
  a_freeze_holds: assert property ((O_CONVERSION_COMPLETE && !I_FREEZE_N && I_CONV_BEGIN_N)[*4]
    |=> $stable(O_RESULT_BITS)) else $error("result moved while frozen");
  a_track_step: assert property (s_tracking |=>
    (O_RESULT_BITS - $past(O_RESULT_BITS)) inside {12'h001, 12'hfff}) else $error("bad step");
  a_phase_toggle: assert property (!$past(I_RST) |-> O_PHASE_A_CLK != $past(O_PHASE_A_CLK))
    else $error("phase a not toggling");
  a_phase_lag: assert property (!$past(I_RST) |-> O_PHASE_B_CLK == $past(O_PHASE_A_CLK))
    else $error("phase b not lagging");
endmodule
bind stadc_top stadc_checker u_chk
(
  .I_CLK_SYS, .I_RST, .I_CONV_BEGIN_N, .I_FREEZE_N, .I_FOLLOW_MODE_N, .O_RESULT_BITS,
  .O_CONVERSION_COMPLETE, .O_COMPLETE_DRAIN_N_O, .O_COMPLETE_DRAIN_N_OE, .O_PHASE_A_CLK,
  .O_PHASE_B_CLK
);

// *** verif/stadc_top_bench.sv ***
`timescale 1ns/1ps
module stadc_top_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic start_n = 1'h0;
  logic freeze_n = 1'h1;
  logic follow_n = 1'h1;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] data;
  logic [11:0] level = 12'h000;
  logic [11:0] result;
  logic above, done, drain_o, drain_oe, irq;
  int fail_count = 0;
  int num_checks = 0;
  // Level in the upper half, expected code in the lower half
  logic [23:0] rows [6] = '{24'h00_0000, 24'hff_ffff, 24'h80_0800, 24'h7f_f7ff, 24'hab_cabc,
    24'h00_1001};
  stadc_top uut
  (
    .I_CLK_SYS(clk), .I_RST(rst), .I_CONV_BEGIN_N(start_n), .I_FREEZE_N(freeze_n),
    .I_FOLLOW_MODE_N(follow_n), .I_COMPARATOR_RESULT(above), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_RESULT_BITS(result), .O_CONVERSION_COMPLETE(done),
    .O_COMPLETE_DRAIN_N_O(drain_o), .O_COMPLETE_DRAIN_N_OE(drain_oe), .O_PHASE_A_CLK(),
    .O_PHASE_B_CLK(), .O_IRQ(irq)
  );
  stadc_analog_model model (.i_code(result), .i_level(level), .o_above(above));
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wreg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rreg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 data = rdata;
  endtask
  task automatic convert(input logic [11:0] v);
    int n;
    n = 0;
    @(posedge clk);
    level <= v;
    start_n <= 1'h0;
    repeat (5) @(posedge clk);
    start_n <= 1'h1;
    @(negedge clk);
    while (done !== 1'h1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 40)
    begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic settle_track(input logic [11:0] v, input logic fz, input logic fl);
    @(posedge clk);
    level <= v;
    freeze_n <= fz;
    follow_n <= fl;
    repeat (30) @(posedge clk);
    @(negedge clk);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    check(16'(result), 16'h0800);
    check(16'(done), 16'h0000);
    rreg(stadc_pkg::REG_CONTROL);
    check(data, 16'h0001);
    foreach (rows[i])
    begin
      convert(rows[i][23:12]);
      check(16'(result), 16'(rows[i][11:0]));
      check(16'({drain_oe, drain_o}), 16'h0002);
      $display("conversion row %0d done", i);
    end
    rreg(stadc_pkg::REG_RESULT);
    check(data, 16'h1001);
    check(16'(irq), 16'h0000);
    wreg(stadc_pkg::REG_MASK, 16'h0001);
    @(posedge clk);
    @(negedge clk);
    check(16'(irq), 16'h0001);
    wreg(stadc_pkg::REG_STATUS, 16'h0001);
    @(posedge clk);
    @(negedge clk);
    check(16'(irq), 16'h0000);
    $display("interrupt test done");
    convert(12'h400);
    settle_track(12'h40c, 1'h1, 1'h0);
    check(16'(result[11:3]), 16'h0081);
    settle_track(12'h500, 1'h0, 1'h0);
    check(16'(result[11:3]), 16'h0081);
    settle_track(12'h500, 1'h1, 1'h1);
    check(16'(result[11:3]), 16'h0081);
    follow_n <= 1'h0;
    convert(12'h123);
    check(16'(result[11:3]), 16'h0024);
    $display("tracking test done");
    finish_test();
  end
endmodule
